// *** verilog/gst_regs.svh ***
`ifndef GST_REGS_SVH
`define GST_REGS_SVH
// Byte addresses of the register words.
`define GST_A_CNTL 8'h00
`define GST_A_CNTH 8'h04
`define GST_A_CTRL 8'h08
`define GST_A_GCTL 8'h0C
`define GST_A_CMPL 8'h10
`define GST_A_CMPH 8'h14
`define GST_A_MODE 8'h18
`define GST_A_FLAG 8'h1C
// Counter control fields.
`define GST_C_CS    7:6
`define GST_C_PS    5:4
`define GST_C_OSC   3
`define GST_C_SYNCD 2
`define GST_C_ON    0
`define GST_C_MASK  8'hFD
// Gate control fields.
`define GST_G_GE   7
`define GST_G_POL  6
`define GST_G_TM   5
`define GST_G_SPM  4
`define GST_G_GO   3
`define GST_G_VAL  2
`define GST_G_GSS  1:0
`define GST_G_MASK 8'hFB
// Capture/compare mode and flag fields.
`define GST_M_CAP  0
`define GST_M_CMP  1
`define GST_M_TRIG 2
`define GST_F_OVF  0
`define GST_F_GEV  1
`define GST_F_CEV  2
// Synchronised pin positions.
`define GST_P_EXT  0
`define GST_P_XTAL 1
`define GST_P_SENS 2
`define GST_P_GATE 3
`define GST_P_CMP  4
// Counts and values.
`define GST_INST_TOP 2'h3
`define GST_CNT_MAX  16'hFFFF
`define GST_CNT_ONE  16'h0001
`define GST_RD_NONE  8'h00
`endif

// *** verilog/gst_pkg.sv ***
package gst_pkg;
   typedef enum logic [1:0] {
      GST_CS_INST = 2'b00,
      GST_CS_SYS  = 2'b01,
      GST_CS_PIN  = 2'b10,
      GST_CS_SENS = 2'b11
   } gst_clk_src_t;

   typedef enum logic [1:0] {
      GST_GS_PIN  = 2'b00,
      GST_GS_T8   = 2'b01,
      GST_GS_CMP  = 2'b10,
      GST_GS_RSVD = 2'b11
   } gst_gate_src_t;

   typedef struct packed {
      logic cmp;
      logic gate;
      logic sens;
      logic xtal;
      logic ext;
   } gst_pins_t;

   typedef struct packed {
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic [4:0]  s3;
      logic        src_prev;
      logic        fall_seen;
      logic [1:0]  idiv;
      logic [2:0]  presc;
      logic [15:0] cnt;
      logic [7:0]  ctrl;
      logic [7:0]  gctl;
      logic [15:0] ccpr;
      logic [2:0]  mode;
      logic [2:0]  flags;
      logic        gsrc_prev;
      logic        tgl;
      logic        act_prev;
      logic        win;
      logic        gval;
      logic        mprev;
      logic        cev;
      logic        trig;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } gst_state_t;
endpackage

// *** verilog/gst_timer.sv ***
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "gst_regs.svh"
module gst_timer (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              other_rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire gst_pkg::gst_pins_t pins,
   input  wire logic              t8_overflow,
   input  wire logic              capture_event,
   output logic                   compare_event,
   output logic                   special_trigger,
   output logic                   osc_enable,
   output logic                   overflow_flag,
   output logic                   gate_event_flag,
   output logic                   gate_state_value
);
   gst_pkg::gst_state_t r;
   gst_pkg::gst_state_t n;
   logic       setup;
   logic       wr;
   logic       wr_lo;
   logic       wr_hi;
   logic       wr_gc;
   logic       wr_cmp;
   logic       hit;
   logic [7:0] rd;
   logic [4:0] stg;
   logic       lvl;
   logic       ext_rise;
   logic       itick;
   logic       ctick;
   logic [2:0] ptop;
   logic       cnt_en;
   logic       inc;
   logic       gsrc;
   logic       gsig;
   logic       act;
   logic       match;
   logic       trig_now;
   logic       on;

   always_comb begin
      n = r;
      n.s1 = pins;
      n.s2 = r.s1;
      n.s3 = r.s2;
      on = r.ctrl[`GST_C_ON];
      // APB: registered answer, one wait-free access phase.
      setup = psel & ~penable;
      wr = psel & penable & pwrite & r.pready;
      wr_lo = wr & (paddr == `GST_A_CNTL);
      wr_hi = wr & (paddr == `GST_A_CNTH);
      wr_gc = wr & (paddr == `GST_A_GCTL);
      wr_cmp = wr & ((paddr == `GST_A_CMPL) | (paddr == `GST_A_CMPH));
      hit = 1'b1;
      rd = `GST_RD_NONE;
      unique case (paddr)
         `GST_A_CNTL: rd = r.cnt[7:0];
         `GST_A_CNTH: rd = r.cnt[15:8];
         `GST_A_CTRL: rd = r.ctrl;
         `GST_A_GCTL: begin
            rd = r.gctl;
            rd[`GST_G_VAL] = r.gval;
         end
         `GST_A_CMPL: rd = r.ccpr[7:0];
         `GST_A_CMPH: rd = r.ccpr[15:8];
         `GST_A_MODE: rd = {5'h00, r.mode};
         `GST_A_FLAG: rd = {5'h00, r.flags};
         default:     hit = 1'b0;
      endcase
      n.pready = setup;
      n.pslverr = setup & ~hit;
      if (setup) begin
         n.prdata = {24'h00_0000, rd};
      end

      // Count clock selection and edge qualification.
      n.idiv = r.idiv + 2'h1;
      itick = (r.idiv == `GST_INST_TOP);
      stg = r.ctrl[`GST_C_SYNCD] ? r.s2 : r.s3;
      if (r.ctrl[`GST_C_CS] == gst_pkg::GST_CS_SENS) begin
         lvl = stg[`GST_P_SENS];
      end else if (r.ctrl[`GST_C_OSC]) begin
         lvl = stg[`GST_P_XTAL];
      end else begin
         lvl = stg[`GST_P_EXT];
      end
      n.src_prev = lvl;
      ext_rise = lvl & ~r.src_prev & r.fall_seen;
      if (!on) begin
         n.fall_seen = 1'b0;
      end else if (!lvl) begin
         n.fall_seen = 1'b1;
      end
      unique case (gst_pkg::gst_clk_src_t'(r.ctrl[`GST_C_CS]))
         gst_pkg::GST_CS_INST: ctick = itick;
         gst_pkg::GST_CS_SYS:  ctick = 1'b1;
         gst_pkg::GST_CS_PIN:  ctick = ext_rise;
         gst_pkg::GST_CS_SENS: ctick = ext_rise;
      endcase

      // Gate path: source, toggle, polarity, single pulse.
      unique case (gst_pkg::gst_gate_src_t'(r.gctl[`GST_G_GSS]))
         gst_pkg::GST_GS_PIN:  gsrc = r.s2[`GST_P_GATE];
         gst_pkg::GST_GS_T8:   gsrc = t8_overflow;
         gst_pkg::GST_GS_CMP:  gsrc = r.s2[`GST_P_CMP];
         gst_pkg::GST_GS_RSVD: gsrc = 1'b0;
      endcase
      n.gsrc_prev = gsrc;
      if (!r.gctl[`GST_G_TM] || !on) begin
         n.tgl = 1'b0;
      end else if (gsrc & ~r.gsrc_prev) begin
         n.tgl = ~r.tgl;
      end
      gsig = r.gctl[`GST_G_TM] ? r.tgl : gsrc;
      act = r.gctl[`GST_G_POL] ? gsig : ~gsig;
      n.act_prev = act;
      if (!r.gctl[`GST_G_SPM] || !on) begin
         n.win = 1'b0;
      end else if (r.win && !act && r.act_prev) begin
         n.win = 1'b0;
         n.gctl[`GST_G_GO] = 1'b0;
      end else if (r.gctl[`GST_G_GO] && act && !r.act_prev) begin
         n.win = 1'b1;
      end
      n.gval = r.gctl[`GST_G_SPM] ? n.win : act;
      if (r.gval && !n.gval) begin
         n.flags[`GST_F_GEV] = 1'b1;
      end

      // Prescaler and counter.
      cnt_en = on & (~r.gctl[`GST_G_GE] | r.gval);
      ptop = 3'((4'h1 << r.ctrl[`GST_C_PS]) - 4'h1);
      inc = 1'b0;
      if (!on) begin
         n.presc = 3'h0;
      end else if (ctick && cnt_en) begin
         if (r.presc >= ptop) begin
            n.presc = 3'h0;
            inc = 1'b1;
         end else begin
            n.presc = r.presc + 3'h1;
         end
      end
      match = r.mode[`GST_M_CMP] & (r.cnt == r.ccpr);
      n.mprev = match;
      trig_now = match & ~r.mprev & r.mode[`GST_M_TRIG];
      n.cev = match & ~r.mprev;
      n.trig = trig_now;
      if (n.cev) begin
         n.flags[`GST_F_CEV] = 1'b1;
      end
      if (trig_now) begin
         n.cnt = 16'h0000;
      end else if (inc) begin
         n.cnt = r.cnt + `GST_CNT_ONE;
         if (r.cnt == `GST_CNT_MAX) begin
            n.flags[`GST_F_OVF] = 1'b1;
         end
      end
      if (r.mode[`GST_M_CAP] && capture_event) begin
         n.ccpr = r.cnt;
      end

      // Software writes win over hardware updates, except compare writes in a compare event, clears of a new flag and counter writes under other_rst.
      if (wr_lo) begin
         n.cnt[7:0] = pwdata[7:0];
      end
      if (wr_hi) begin
         n.cnt[15:8] = pwdata[7:0];
      end
      if (wr && paddr == `GST_A_CTRL) begin
         n.ctrl = pwdata[7:0] & `GST_C_MASK;
      end
      if (wr_gc) begin
         n.gctl = pwdata[7:0] & `GST_G_MASK;
      end
      if (wr && paddr == `GST_A_CMPL && !n.cev) begin
         n.ccpr[7:0] = pwdata[7:0];
      end
      if (wr && paddr == `GST_A_CMPH && !n.cev) begin
         n.ccpr[15:8] = pwdata[7:0];
      end
      if (wr && paddr == `GST_A_MODE) begin
         n.mode = pwdata[2:0];
      end
      if (wr && paddr == `GST_A_FLAG) begin
         // Write one to clear; a flag first set by an event in the same cycle stays set.
         n.flags = n.flags & ~(pwdata[2:0] & ~(n.flags & ~r.flags));
      end
      // Other resets clear the count path but keep control bits.
      if (other_rst) begin
         n.cnt = 16'h0000;
         n.presc = 3'h0;
         n.win = 1'b0;
         n.tgl = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign compare_event = r.cev;
   assign special_trigger = r.trig;
   assign osc_enable = r.ctrl[`GST_C_OSC];
   assign overflow_flag = r.flags[`GST_F_OVF];
   assign gate_event_flag = r.flags[`GST_F_GEV];
   assign gate_state_value = r.gval;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence armed_s;
      r.ctrl[`GST_C_ON] && r.gctl[`GST_G_SPM] && r.win;
   endsequence
   sequence trail_s;
      !act && r.act_prev && !wr_gc && !other_rst;
   endsequence
   sequence calm_s;
      !wr_lo && !wr_hi && !other_rst;
   endsequence

   cap_copy_a: assert property (r.mode[`GST_M_CAP] && capture_event
      |=> r.ccpr == $past(r.cnt)) else $error("capture missed count");
   cmp_event_a: assert property (match && !r.mprev
      |=> compare_event ##1 !compare_event) else $error("compare event wrong");
   trig_clr_a: assert property (trig_now ##0 calm_s
      |=> r.cnt == 16'h0000 && special_trigger) else $error("trigger no clear");
   trig_novf_a: assert property (trig_now ##0 calm_s
      |=> $stable(overflow_flag)) else $error("trigger set overflow");
   wr_wins_a: assert property (wr_lo && trig_now && !other_rst
      |=> r.cnt[7:0] == $past(pwdata[7:0])) else $error("write lost");
   off_hold_a: assert property (!on ##0 calm_s
      |=> $stable(r.cnt)) else $error("counter moved while off");
   gate_hold_a: assert property (on && r.gctl[`GST_G_GE] && !r.gval
      && !trig_now ##0 calm_s |=> $stable(r.cnt)) else $error("gate leak");
   tgl_clr_a: assert property (!r.gctl[`GST_G_TM]
      |=> !r.tgl) else $error("toggle not held clear");
   roll_over_a: assert property (inc && r.cnt == `GST_CNT_MAX && !trig_now
      ##0 calm_s |=> r.cnt == 16'h0000 && overflow_flag)
      else $error("rollover wrong");
   gate_fall_a: assert property ($fell(r.gval)
      |-> gate_event_flag) else $error("gate flag not set");
   spm_done_a: assert property (armed_s ##0 trail_s
      |=> !r.gctl[`GST_G_GO] && !r.win ##1 !r.win)
      else $error("single pulse not ended");
   apb_answer_a: assert property (psel && !penable
      |=> pready ##1 !pready) else $error("apb answer timing");
   apb_err_a: assert property (psel && !penable && !hit
      |=> pready && pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");

   // A rising gate source edge while toggling, seen with the counter on.
   sequence gate_rise_s;
      on && r.gctl[`GST_G_TM] && gsrc && !r.gsrc_prev && !other_rst;
   endsequence
   // An armed single-pulse acquisition meeting the active gate edge.
   sequence pulse_open_s;
      on && r.gctl[`GST_G_SPM] && r.gctl[`GST_G_GO] && !r.win && act && !r.act_prev;
   endsequence

   tgl_flip_a: assert property (gate_rise_s
      |=> r.tgl != $past(r.tgl))
      else $error("toggle did not flip");
   tgl_off_a: assert property (!on
      |=> !r.tgl)
      else $error("toggle kept while off");
   spm_off_a: assert property (!r.gctl[`GST_G_SPM]
      |=> !r.win)
      else $error("pulse window open without mode");
   spm_open_a: assert property (pulse_open_s ##0 !other_rst
      |=> r.win && gate_state_value)
      else $error("pulse window did not open");
   go_hold_a: assert property (!r.win && !wr_gc
      |=> $stable(r.gctl[`GST_G_GO]))
      else $error("go bit changed outside window");
   gval_track_a: assert property (!r.gctl[`GST_G_SPM]
      |=> gate_state_value == $past(act))
      else $error("gate state not tracking");

   // Gate source selection, seen through the gate state with no toggling, and the gate event flag holding until written.
   rsvd_low_a: assert property (r.gctl[`GST_G_GSS] == gst_pkg::GST_GS_RSVD
      && !r.gctl[`GST_G_TM] && r.gctl[`GST_G_POL] && !r.gctl[`GST_G_SPM] |=> !gate_state_value)
      else $error("reserved gate source not low");
   t8_gate_a: assert property (r.gctl[`GST_G_GSS] == gst_pkg::GST_GS_T8
      && !r.gctl[`GST_G_TM] && r.gctl[`GST_G_POL] && !r.gctl[`GST_G_SPM] && t8_overflow
      |=> gate_state_value) else $error("overflow gate pulse lost");
   flag_keep_a: assert property (gate_event_flag && !(wr && paddr == `GST_A_FLAG)
      |=> gate_event_flag)
      else $error("gate flag dropped");

   // Clock, prescaler and count stepping.
   osc_wr_a: assert property (wr && paddr == `GST_A_CTRL
      |=> osc_enable == $past(pwdata[`GST_C_OSC]))
      else $error("oscillator enable not written");
   sys_step_a: assert property (ctick && cnt_en && ptop == 3'h0 && !trig_now ##0 calm_s
      |=> r.cnt == 16'($past(r.cnt) + `GST_CNT_ONE))
      else $error("count did not step");
   inst_gap_a: assert property (on && r.ctrl[`GST_C_CS] == gst_pkg::GST_CS_INST
      && !itick && !other_rst |=> $stable(r.presc))
      else $error("instruction clock ticked early");
   presc_step_a: assert property (ctick && cnt_en && r.presc < ptop && !other_rst
      |=> r.presc == 3'($past(r.presc) + 3'h1))
      else $error("prescaler did not advance");
   presc_off_a: assert property (!on && !other_rst
      |=> r.presc == 3'h0)
      else $error("prescaler kept while off");
   fall_clr_a: assert property (!on
      |=> !r.fall_seen)
      else $error("falling edge kept while off");
   ovf_only_a: assert property ($rose(overflow_flag)
      |-> $past(inc) && $past(r.cnt) == `GST_CNT_MAX)
      else $error("overflow flag without rollover");

   // Compare outputs and the other resets.
   trig_pulse_a: assert property (special_trigger
      |-> compare_event)
      else $error("trigger without compare event");
   cmp_flag_a: assert property (compare_event
      |-> r.flags[`GST_F_CEV])
      else $error("compare flag not set");
   orst_keep_a: assert property (other_rst && !wr
      |=> r.cnt == 16'h0000 && $stable(r.ctrl) && $stable(r.mode))
      else $error("other reset handled wrong");

endmodule // gst_timer

// *** testbench/gst_far.sv ***
`timescale 1ns/10ps
module gst_far (
   input  wire logic          pclk,
   output gst_pkg::gst_pins_t pins,
   output logic               t8_ovf,
   output logic               cap
);
   logic [4:0] p = 5'h00;
   assign pins = p;
   initial begin
      t8_ovf = 1'b0;
      cap = 1'b0;
   end
   // Pins idle low and stand still between bursts.
   task automatic pulse(input int i, input int n);
      repeat (n) begin
         repeat (4) @(posedge pclk);
         p[i] <= 1'b1;
         repeat (4) @(posedge pclk);
         p[i] <= 1'b0;
      end
   endtask
   task automatic level(input int i, input logic v);
      @(posedge pclk);
      p[i] <= v;
   endtask
   task automatic ovf_pulse;
      @(posedge pclk);
      t8_ovf <= 1'b1;
      @(posedge pclk);
      t8_ovf <= 1'b0;
   endtask
   task automatic strobe_cap;
      @(posedge pclk);
      cap <= 1'b1;
      @(posedge pclk);
      cap <= 1'b0;
   endtask
endmodule // gst_far

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`include "gst_regs.svh"
module tb_top;
   logic               pclk;
   logic               presetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   gst_pkg::gst_pins_t pins;
   logic               t8_ovf;
   logic               cap;
   logic               cmp_ev;
   logic               trig;
   logic               osc_en;
   logic               ovf;
   logic               gev;
   logic               gval;
   logic [31:0]        rd;
   logic               er;
   logic               orst;
   int                 bad_count = 0;
   int                 num_checks = 0;
   int                 cyc = 0;

   gst_timer u_gst_timer (.pclk(pclk), .presetn(presetn), .other_rst(orst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(pins), .t8_overflow(t8_ovf),
      .capture_event(cap), .compare_event(cmp_ev), .special_trigger(trig),
      .osc_enable(osc_en), .overflow_flag(ovf), .gate_event_flag(gev),
      .gate_state_value(gval));
   gst_far u_gst_far (.pclk(pclk), .pins(pins), .t8_ovf(t8_ovf), .cap(cap));

   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      num_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         bad_count++;
         $display("Error at %0t got %h exp %h to %h", $time, got, lo, hi);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic setcnt(input logic [15:0] v);
      wr(`GST_A_CNTL, {24'h00_0000, v[7:0]});
      wr(`GST_A_CNTH, {24'h00_0000, v[15:8]});
   endtask

   task automatic t_regs;
      rdc(`GST_A_CTRL, 32'h0000_0000);
      apb(1'b0, `GST_A_GCTL, 32'h0000_0000);
      chk(rd & 32'h0000_00FB, 32'h0000_0000);
      wr(`GST_A_CTRL, 32'h0000_00FF);
      rdc(`GST_A_CTRL, 32'h0000_00FD);
      wr(`GST_A_CTRL, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001);
      setcnt(16'h1234);
      rdc(`GST_A_CNTL, 32'h0000_0034);
      rdc(`GST_A_CNTH, 32'h0000_0012);
   endtask
   task automatic t_rates;
      int e;
      for (int cs = 0; cs < 2; cs++) begin
         for (int ps = 0; ps < 4; ps++) begin
            e = (cs != 0 ? 64 : 16) >> ps;
            setcnt(16'h0000);
            wr(`GST_A_CTRL, 32'(cs * 64 + ps * 16 + 1));
            repeat (61) @(posedge pclk);
            wr(`GST_A_CTRL, 32'h0000_0000);
            apb(1'b0, `GST_A_CNTL, 32'h0000_0000);
            chk_rng(rd, e - 1, e + 1);
         end
      end
   endtask
   task automatic t_pins;
      logic [7:0] c [3];
      c = '{8'h81, 8'h8D, 8'hC1};
      for (int i = 0; i < 3; i++) begin
         setcnt(16'h0000);
         wr(`GST_A_CTRL, {24'h00_0000, c[i]});
         u_gst_far.pulse(i, 5);
         chk({31'h0, osc_en}, {31'h0, c[i][3]});
         repeat (4) @(posedge pclk);
         wr(`GST_A_CTRL, 32'h0000_0000);
         rdc(`GST_A_CNTL, 32'h0000_0005);
      end
   endtask
   task automatic t_trig;
      int n;
      setcnt(16'h0000);
      wr(`GST_A_CMPL, 32'h0000_0010);
      wr(`GST_A_CMPH, 32'h0000_0000);
      wr(`GST_A_MODE, 32'h0000_0006);
      wr(`GST_A_FLAG, 32'h0000_0007);
      wr(`GST_A_CTRL, 32'h0000_0001);
      n = 0;
      while (cmp_ev !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk_rng(n, 60, 72);
      chk({31'h0, trig}, 32'h0000_0001);
      wr(`GST_A_CTRL, 32'h0000_0000);
      apb(1'b0, `GST_A_CNTL, 32'h0000_0000);
      chk_rng(rd, 0, 4);
      chk({31'h0, ovf}, 32'h0000_0000);
      wr(`GST_A_MODE, 32'h0000_0000);
      setcnt(16'hFFFE);
      wr(`GST_A_CTRL, 32'h0000_0041);
      wr(`GST_A_CTRL, 32'h0000_0000);
      chk({31'h0, ovf}, 32'h0000_0001);
      rdc(`GST_A_CNTH, 32'h0000_0000);
   endtask
   task automatic t_cap_gate;
      wr(`GST_A_MODE, 32'h0000_0001);
      setcnt(16'h0A55);
      u_gst_far.strobe_cap();
      @(posedge pclk);
      rdc(`GST_A_CMPL, 32'h0000_0055);
      rdc(`GST_A_CMPH, 32'h0000_000A);
      setcnt(16'h0000);
      wr(`GST_A_GCTL, 32'h0000_00C0);
      wr(`GST_A_CTRL, 32'h0000_0041);
      repeat (20) @(posedge pclk);
      wr(`GST_A_CTRL, 32'h0000_0000);
      rdc(`GST_A_CNTL, 32'h0000_0000);
      wr(`GST_A_FLAG, 32'h0000_0007);
      u_gst_far.level(3, 1'b1);
      repeat (6) @(posedge pclk);
      chk({30'h0, gval, gev}, 32'h0000_0002);
      u_gst_far.level(3, 1'b0);
      repeat (6) @(posedge pclk);
      chk({31'h0, gev}, 32'h0000_0001);
   endtask
   task automatic t_modes;
      wr(`GST_A_FLAG, 32'h0000_0007);
      setcnt(16'h00AB);
      wr(`GST_A_CTRL, 32'h0000_0008);
      @(posedge pclk);
      orst <= 1'b1;
      @(posedge pclk);
      orst <= 1'b0;
      rdc(`GST_A_CNTL, 32'h0000_0000);
      rdc(`GST_A_CTRL, 32'h0000_0008);
      wr(`GST_A_GCTL, 32'h0000_00E0);
      wr(`GST_A_CTRL, 32'h0000_0041);
      u_gst_far.level(3, 1'b1);
      u_gst_far.level(3, 1'b0);
      repeat (20) @(posedge pclk);
      wr(`GST_A_CTRL, 32'h0000_0000);
      apb(1'b0, `GST_A_CNTL, 32'h0000_0000);
      chk_rng(rd, 18, 22);
      setcnt(16'h0000);
      wr(`GST_A_GCTL, 32'h0000_00D8);
      wr(`GST_A_CTRL, 32'h0000_0041);
      for (int k = 0; k < 2; k++) begin
         u_gst_far.level(3, 1'b1);
         repeat (8) @(posedge pclk);
         u_gst_far.level(3, 1'b0);
         repeat (6) @(posedge pclk);
         rdc(`GST_A_GCTL, 32'h0000_00D0);
      end
      wr(`GST_A_CTRL, 32'h0000_0000);
      apb(1'b0, `GST_A_CNTL, 32'h0000_0000);
      chk_rng(rd, 8, 10);
      wr(`GST_A_GCTL, 32'h0000_0041);
      wr(`GST_A_FLAG, 32'h0000_0007);
      u_gst_far.ovf_pulse();
      repeat (3) @(posedge pclk);
      chk({31'h0, gev}, 32'h0000_0001);
      wr(`GST_A_GCTL, 32'h0000_0042);
      u_gst_far.level(4, 1'b1);
      repeat (6) @(posedge pclk);
      chk({31'h0, gval}, 32'h0000_0001);
      wr(`GST_A_GCTL, 32'h0000_0043);
      rdc(`GST_A_GCTL, 32'h0000_0043);
      u_gst_far.level(4, 1'b0);
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      presetn = 1'b0;
      orst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_rates();
      t_pins();
      t_trig();
      t_cap_gate();
      t_modes();
      final_report();
   end
endmodule // tb_top
